// [reset_source_combiner_status.sv]
`timescale 1ns/1ps
`include "rst_combiner_defines.svh"

// What this block does
// - Master reset is active while any reset source is active.
// - Nine sources feed the master reset, power-on through uninitialized register access.
// - Each reset sets the cause flag of the source that caused it.
// - Power-on clears the register except brown-out and power-on flags, which set.
// - Software may write any flag; writing one never causes a reset.
// - Bit 15 flags a trap conflict reset.
// - Bit 14 flags illegal opcode, addressing mode or uninitialized register reset.
// - Bit 12 selects retention supply in sleep, ignored when low-power fuse is one.
// - Bit 10 reads one after deep sleep.
// - Bit 9 flags configuration mismatch reset.
// - Bit 8 keeps flash bias powered in sleep when one.
// - Bit 7 flags a master clear pin reset.
// - Bit 6 flags a reset instruction.
// - Bit 5 enables watchdog; fuse pair all ones forces it on.
// - Bit 4 flags a watchdog time-out.
// - Bit 3 reads one after sleep.
// - Bit 2 reads one after idle.
// - Bit 1 set by brown-out and by power-on reset.
// - Bit 0 set by power-on reset.
// - Bits 13 and 11 always read zero.
// - Watchdog time-out flag cleared by watchdog clear and power-save instructions.
// - Deep sleep flag set by power-save zero while deep sleep arm is set.
module reset_source_combiner_status
	import rst_combiner_pkg::*;
(
	input  wire logic        I_CLK,
	input  wire logic        I_RST_B,
	// APB slave
	input  wire logic        I_PSEL,
	input  wire logic        I_PENABLE,
	input  wire logic        I_PWRITE,
	input  wire logic [11:0] I_PADDR,
	input  wire logic [31:0] I_PWDATA,
	input  wire logic [3:0]  I_PSTRB,
	output logic      [31:0] O_PRDATA,
	output logic             O_PREADY,
	output logic             O_PSLVERR,
	// Reset sources (asynchronous to I_CLK)
	input  wire logic        I_POWER_ON_RST,
	input  wire logic        I_MASTER_CLEAR_PIN,
	input  wire logic        I_SOFT_RESET_INSTR,
	input  wire logic        I_WDOG_TIMEOUT,
	input  wire logic        I_BROWNOUT,
	input  wire logic        I_CFG_MISMATCH,
	input  wire logic        I_TRAP_CONFLICT,
	input  wire logic        I_BAD_OPCODE,
	input  wire logic        I_UNINIT_WREG_RESET,
	// Core events, same clock domain, one-cycle pulses
	input  wire logic        I_WATCHDOG_CLEAR_INSTR,
	input  wire logic        I_POWER_SAVE_INSTR,
	input  wire logic        I_POWER_SAVE_OPERAND,
	input  wire logic        I_DEEP_SLEEP_ARM,
	// Configuration fuses, static
	input  wire logic        I_LOW_POWER_REGULATOR_CFG,
	input  wire logic [1:0]  I_WATCHDOG_FUSE_ENABLE,
	// Outputs
	output logic             O_MASTER_RESET,
	output logic             O_RETENTION_SUPPLY_EN,
	output logic             O_FLASH_BIAS_IN_SLEEP,
	output logic             O_WATCHDOG_ENABLE
);

	// ----------------------------------------------------------------
	// Source synchronisers
	// ----------------------------------------------------------------
	logic [`NUM_SOURCES-1:0] src_raw;
	logic [`NUM_SOURCES-1:0] src_meta_r;
	logic [`NUM_SOURCES-1:0] src_sync_r;
	logic [`NUM_SOURCES-1:0] src_prev_r;
	logic [`NUM_SOURCES-1:0] src_rise;
	logic                    any_src;

	assign src_raw = {I_UNINIT_WREG_RESET, I_BAD_OPCODE, I_TRAP_CONFLICT, I_CFG_MISMATCH,
		I_BROWNOUT, I_WDOG_TIMEOUT, I_SOFT_RESET_INSTR, I_MASTER_CLEAR_PIN, I_POWER_ON_RST};

	genvar g;
	generate
		for (g = 0; g < `NUM_SOURCES; g++)
		begin : g_sync
			always_ff @(posedge I_CLK)
			begin
				if (!I_RST_B)
				begin
					src_meta_r[g] <= 1'b0;
					src_sync_r[g] <= 1'b0;
					src_prev_r[g] <= 1'b0;
				end
				else
				begin
					src_meta_r[g] <= src_raw[g];
					src_sync_r[g] <= src_meta_r[g];
					src_prev_r[g] <= src_sync_r[g];
				end
			end
			assign src_rise[g] = src_sync_r[g] & ~src_prev_r[g];
		end
	endgenerate

	assign any_src = |src_sync_r;

	// ----------------------------------------------------------------
	// Fuse synchronisers
	// ----------------------------------------------------------------
	// Fuses settle during power-up, independent of this clock.
	// Two stages keep a late-settling fuse from reaching the outputs
	// or the status word half-resolved; the cost is two cycles of lag.
	logic       lp_cfg_meta_r;
	logic       lp_cfg_sync_r;
	logic [1:0] wdog_fuse_meta_r;
	logic [1:0] wdog_fuse_sync_r;

	always_ff @(posedge I_CLK)
	begin
		if (!I_RST_B)
		begin
			lp_cfg_meta_r    <= 1'b0;
			lp_cfg_sync_r    <= 1'b0;
			wdog_fuse_meta_r <= 2'h0;
			wdog_fuse_sync_r <= 2'h0;
		end
		else
		begin
			lp_cfg_meta_r    <= I_LOW_POWER_REGULATOR_CFG;
			lp_cfg_sync_r    <= lp_cfg_meta_r;
			wdog_fuse_meta_r <= I_WATCHDOG_FUSE_ENABLE;
			wdog_fuse_sync_r <= wdog_fuse_meta_r;
		end
	end

	// ----------------------------------------------------------------
	// Master reset sequencer
	// ----------------------------------------------------------------
	localparam logic [3:0] REL_CYC = 4'(`RELEASE_CYCLES);

	rst_state_t state_r;
	logic [3:0] rel_cnt_r;
	logic       master_r;

	always_ff @(posedge I_CLK)
	begin
		if (!I_RST_B)
		begin
			state_r   <= ST_HOLD;
			rel_cnt_r <= 4'h0;
			master_r  <= 1'b1;
		end
		else
		begin
			case (state_r)
				ST_RUN:
				begin
					if (any_src)
					begin
						state_r  <= ST_HOLD;
						master_r <= 1'b1;
					end
				end
				ST_HOLD:
				begin
					master_r <= 1'b1;
					if (!any_src)
					begin
						state_r   <= ST_RELEASE;
						rel_cnt_r <= REL_CYC;
					end
				end
				ST_RELEASE:
				begin
					if (any_src)
						state_r <= ST_HOLD;
					else if (rel_cnt_r <= 4'h1)
					begin
						state_r  <= ST_RUN;
						master_r <= 1'b0;
					end
					else
						rel_cnt_r <= rel_cnt_r - 4'h1;
				end
				default:
				begin
					state_r  <= ST_HOLD;
					master_r <= 1'b1;
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Cause and control register
	// ----------------------------------------------------------------
	function automatic logic hit(input logic [11:0] addr, input logic [11:0] off);
		hit = (addr[11:2] == off[11:2]);
	endfunction : hit

	// Only byte lanes 0 and 1 carry register bits; lanes 2 and 3 are ignored
	function automatic logic [15:0] lane_mask(input logic [3:0] strb);
		lane_mask = {{8{strb[1]}}, {8{strb[0]}}};
	endfunction : lane_mask

	logic        apb_write;
	logic        cause_wr;
	logic [15:0] cause_r;
	logic [15:0] cause_nxt;
	logic [15:0] wr_mask;
	logic        pwr_on_ev;

	assign apb_write = I_PSEL & I_PENABLE & I_PWRITE;
	// Write lands only at the edge where ready is seen high, once per transfer
	assign cause_wr  = apb_write & O_PREADY & hit(I_PADDR, `CAUSE_CTRL_OFFSET);
	assign wr_mask   = lane_mask(I_PSTRB);
	assign pwr_on_ev = src_rise[SRC_POWER_ON];

	always_comb
	begin
		cause_nxt = cause_r;
		// Software write first so hardware sets below win the same cycle
		if (cause_wr)
			cause_nxt = (cause_r & ~wr_mask) | (I_PWDATA[15:0] & wr_mask);
		if (I_WATCHDOG_CLEAR_INSTR || I_POWER_SAVE_INSTR)
			cause_nxt[`BIT_WDOG_TIMEOUT] = 1'b0;
		if (I_POWER_SAVE_INSTR && !I_POWER_SAVE_OPERAND)
		begin
			cause_nxt[`BIT_SLEEP] = 1'b1;
			if (I_DEEP_SLEEP_ARM)
				cause_nxt[`BIT_DEEP_SLEEP] = 1'b1;
		end
		if (I_POWER_SAVE_INSTR && I_POWER_SAVE_OPERAND)
			cause_nxt[`BIT_IDLE] = 1'b1;
		if (src_rise[SRC_TRAP])
			cause_nxt[`BIT_TRAP_CONFLICT] = 1'b1;
		if (src_rise[SRC_BAD_OPCODE] || src_rise[SRC_UNINIT_WREG])
			cause_nxt[`BIT_BAD_OPCODE] = 1'b1;
		if (src_rise[SRC_CFG_MISMATCH])
			cause_nxt[`BIT_CFG_MISMATCH] = 1'b1;
		if (src_rise[SRC_PIN])
			cause_nxt[`BIT_PIN_RESET] = 1'b1;
		if (src_rise[SRC_SOFT])
			cause_nxt[`BIT_SOFT_RESET] = 1'b1;
		if (src_rise[SRC_WDOG])
			cause_nxt[`BIT_WDOG_TIMEOUT] = 1'b1;
		if (src_rise[SRC_BROWNOUT])
			cause_nxt[`BIT_BROWNOUT] = 1'b1;
		// Power-on overrides everything else
		if (pwr_on_ev)
			cause_nxt = `CAUSE_POR_VALUE;
		cause_nxt = cause_nxt & `CAUSE_IMPL_MASK;
	end

	// Register reset models a power-on: the same value as a power-on event
	always_ff @(posedge I_CLK)
	begin
		if (!I_RST_B)
			cause_r <= `CAUSE_POR_VALUE;
		else
			cause_r <= cause_nxt;
	end

	// ----------------------------------------------------------------
	// Control outputs
	// ----------------------------------------------------------------
	always_ff @(posedge I_CLK)
	begin
		if (!I_RST_B)
		begin
			O_RETENTION_SUPPLY_EN <= 1'b0;
			O_FLASH_BIAS_IN_SLEEP <= 1'b0;
			O_WATCHDOG_ENABLE     <= 1'b0;
		end
		else
		begin
			O_RETENTION_SUPPLY_EN <= cause_r[`BIT_HOLD_ENABLE] & ~lp_cfg_sync_r;
			O_FLASH_BIAS_IN_SLEEP <= cause_r[`BIT_FLASH_BIAS];
			O_WATCHDOG_ENABLE     <= cause_r[`BIT_WDOG_SOFT_EN] |
				(wdog_fuse_sync_r == `WDOG_FUSE_ALL_ONES);
		end
	end

	// Master reset also follows any_src directly, so a new source is not
	// delayed by the sequencer's state change
	always_ff @(posedge I_CLK)
	begin
		if (!I_RST_B)
			O_MASTER_RESET <= 1'b1;
		else
			O_MASTER_RESET <= master_r | any_src;
	end

	// ----------------------------------------------------------------
	// APB slave: answers in the access cycle's following edge
	// ----------------------------------------------------------------
	logic [31:0] rd_val;

	always_comb
	begin
		rd_val = 32'h0000_0000;
		if (hit(I_PADDR, `CAUSE_CTRL_OFFSET))
			rd_val = {16'h0000, cause_r};
		else if (hit(I_PADDR, `CFG_STAT_OFFSET))
			rd_val = {27'h000_0000, master_r, state_r == ST_RUN, wdog_fuse_sync_r,
				lp_cfg_sync_r};
	end

	// One wait state: ready rises one edge after the access phase begins
	always_ff @(posedge I_CLK)
	begin
		if (!I_RST_B)
		begin
			O_PREADY  <= 1'b0;
			O_PRDATA  <= 32'h0000_0000;
			O_PSLVERR <= 1'b0;
		end
		else if (I_PSEL && I_PENABLE && !O_PREADY)
		begin
			O_PREADY  <= 1'b1;
			O_PRDATA  <= I_PWRITE ? 32'h0000_0000 : rd_val;
			O_PSLVERR <= !(hit(I_PADDR, `CAUSE_CTRL_OFFSET) ||
				(hit(I_PADDR, `CFG_STAT_OFFSET) && !I_PWRITE));
		end
		else
		begin
			O_PREADY  <= 1'b0;
			O_PSLVERR <= 1'b0;
		end
	end

endmodule : reset_source_combiner_status

// [reset_source_combiner_status_chk.sv]
`timescale 1ns/1ps
module rscs_chk
(
	input wire logic        I_CLK,
	input wire logic        I_RST_B,
	input wire logic        I_PSEL,
	input wire logic        I_PENABLE,
	input wire logic        I_PWRITE,
	input wire logic [11:0] I_PADDR,
	input wire logic [31:0] O_PRDATA,
	input wire logic        O_PREADY,
	input wire logic        O_PSLVERR,
	input wire logic        I_POWER_ON_RST,
	input wire logic        I_MASTER_CLEAR_PIN,
	input wire logic        I_SOFT_RESET_INSTR,
	input wire logic        I_WDOG_TIMEOUT,
	input wire logic        I_BROWNOUT,
	input wire logic        I_CFG_MISMATCH,
	input wire logic        I_TRAP_CONFLICT,
	input wire logic        I_BAD_OPCODE,
	input wire logic        I_UNINIT_WREG_RESET,
	input wire logic        I_LOW_POWER_REGULATOR_CFG,
	input wire logic [1:0]  I_WATCHDOG_FUSE_ENABLE,
	input wire logic        O_MASTER_RESET,
	input wire logic        O_RETENTION_SUPPLY_EN,
	input wire logic        O_WATCHDOG_ENABLE
);
	logic any_src;
	assign any_src = I_POWER_ON_RST | I_MASTER_CLEAR_PIN | I_SOFT_RESET_INSTR | I_WDOG_TIMEOUT | I_BROWNOUT
		| I_CFG_MISMATCH | I_TRAP_CONFLICT | I_BAD_OPCODE | I_UNINIT_WREG_RESET;
	default clocking cb @(posedge I_CLK); endclocking
	default disable iff (!I_RST_B);
	a_src_master: assert property (any_src |-> ##[0:4] O_MASTER_RESET)
		else $error("master reset missed a source");
	a_master_hold: assert property ($fell(O_MASTER_RESET) |-> !$past(any_src) && !$past(any_src, 3))
		else $error("master reset dropped early");
	a_master_release: assert property (!any_src [*8] |-> ##[0:8] !O_MASTER_RESET)
		else $error("master reset stuck");
	a_ready_wait: assert property (I_PSEL && I_PENABLE && !O_PREADY |=> O_PREADY)
		else $error("no ready");
	a_ready_pulse: assert property (O_PREADY |=> !O_PREADY)
		else $error("ready too long");
	a_unmapped_err: assert property (O_PREADY && $past(I_PADDR) != 12'h000 && $past(I_PADDR) != 12'h004
		|-> O_PSLVERR) else $error("unmapped access accepted");
	a_unimpl_zero: assert property (O_PREADY && $past(I_PADDR) == 12'h000 && !$past(I_PWRITE)
		|-> (O_PRDATA & 32'hFFFF_2800) == 32'h0000_0000) else $error("unused bits set");
	a_hold_fuse: assert property ($past(I_LOW_POWER_REGULATOR_CFG) && $past(I_LOW_POWER_REGULATOR_CFG, 2)
		&& $past(I_LOW_POWER_REGULATOR_CFG, 3) |-> !O_RETENTION_SUPPLY_EN) else $error("retention ignores fuse");
	a_wdog_fuse: assert property ($past(I_WATCHDOG_FUSE_ENABLE, 2) == 2'h3 && $past(I_WATCHDOG_FUSE_ENABLE, 3) == 2'h3
		&& $past(I_RST_B) && $past(I_RST_B, 2) && $past(I_RST_B, 3) |-> O_WATCHDOG_ENABLE)
		else $error("watchdog not forced");
endmodule : rscs_chk

bind reset_source_combiner_status rscs_chk i_chk (.*);

// [rst_combiner_defines.svh]
`ifndef RST_COMBINER_DEFINES_SVH
`define RST_COMBINER_DEFINES_SVH

// Register byte offsets
`define CAUSE_CTRL_OFFSET   12'h000
`define CFG_STAT_OFFSET     12'h004

// Field positions in reset_cause_control
`define BIT_TRAP_CONFLICT   15
`define BIT_BAD_OPCODE      14
`define BIT_HOLD_ENABLE     12
`define BIT_DEEP_SLEEP      10
`define BIT_CFG_MISMATCH    9
`define BIT_FLASH_BIAS      8
`define BIT_PIN_RESET       7
`define BIT_SOFT_RESET      6
`define BIT_WDOG_SOFT_EN    5
`define BIT_WDOG_TIMEOUT    4
`define BIT_SLEEP           3
`define BIT_IDLE            2
`define BIT_BROWNOUT        1
`define BIT_POWER_ON        0

// Implemented-bit mask: positions 13 and 11 are absent
`define CAUSE_IMPL_MASK     16'hD7FF
`define CAUSE_POR_VALUE     16'h0003
`define WDOG_FUSE_ALL_ONES  2'h3

// Number of reset sources and master-reset hold after release
`define NUM_SOURCES         9
`define RELEASE_TIME_NS     20
`define CLK_PERIOD_NS       10
`define RELEASE_CYCLES      ((`RELEASE_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// [rst_combiner_pkg.sv]
package rst_combiner_pkg;

	typedef enum logic [3:0]
	{
		SRC_POWER_ON,
		SRC_PIN,
		SRC_SOFT,
		SRC_WDOG,
		SRC_BROWNOUT,
		SRC_CFG_MISMATCH,
		SRC_TRAP,
		SRC_BAD_OPCODE,
		SRC_UNINIT_WREG
	} reset_src_t;

	typedef enum
	{
		ST_RUN,
		ST_HOLD,
		ST_RELEASE
	} rst_state_t;

endpackage : rst_combiner_pkg

// [test_reset_source_combiner_status.sv]
`timescale 1ns/1ps
module test_reset_source_combiner_status;
	logic        clk, rst_b, psel, pen, pwr, cfg, wclr, ps, psop, arm, e, rdy, err, mr, ret, fb, we;
	logic [11:0] addr;
	logic [31:0] wd, rd, lf, prd;
	logic [8:0]  src;
	logic [1:0]  fz;
	logic [15:0] flg [9];
	int          fail_count, n_tests, cyc;

	reset_source_combiner_status i_dut (.I_CLK(clk), .I_RST_B(rst_b), .I_PSEL(psel), .I_PENABLE(pen),
		.I_PWRITE(pwr), .I_PADDR(addr), .I_PWDATA(wd), .I_PSTRB(4'h3), .O_PRDATA(prd), .O_PREADY(rdy),
		.O_PSLVERR(err), .I_POWER_ON_RST(src[0]), .I_MASTER_CLEAR_PIN(src[1]), .I_SOFT_RESET_INSTR(src[2]),
		.I_WDOG_TIMEOUT(src[3]), .I_BROWNOUT(src[4]), .I_CFG_MISMATCH(src[5]), .I_TRAP_CONFLICT(src[6]),
		.I_BAD_OPCODE(src[7]), .I_UNINIT_WREG_RESET(src[8]), .I_WATCHDOG_CLEAR_INSTR(wclr),
		.I_POWER_SAVE_INSTR(ps), .I_POWER_SAVE_OPERAND(psop), .I_DEEP_SLEEP_ARM(arm),
		.I_LOW_POWER_REGULATOR_CFG(cfg), .I_WATCHDOG_FUSE_ENABLE(fz), .O_MASTER_RESET(mr),
		.O_RETENTION_SUPPLY_EN(ret), .O_FLASH_BIAS_IN_SLEEP(fb), .O_WATCHDOG_ENABLE(we));

	function automatic logic [31:0] nx(input logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction : nx

	task conclude;
		if (fail_count == 0 && n_tests > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : conclude

	task chk(input logic [31:0] g, input logic [31:0] x);
		n_tests++;
		if (g !== x)
		begin
			fail_count++;
			$display("unexpected at %0t: got %h expected %h", $time, g, x);
		end
	endtask : chk

	// Called just after a rising edge; ready is read before that edge's updates land
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		psel <= 1'b1;
		pwr <= w;
		addr <= a;
		wd <= d;
		@(posedge clk);
		pen <= 1'b1;
		n = 0;
		do
		begin
			@(posedge clk);
			n++;
		end
		while (rdy !== 1'b1 && n < 50);
		rd = prd;
		e = err;
		psel <= 1'b0;
		pen <= 1'b0;
		@(posedge clk);
	endtask : apb

	task wrel;
		for (int n = 0; n < 50 && mr !== 1'b0; n++)
			@(posedge clk);
	endtask : wrel

	// Sets the timeout flag, fires one core event, reads back the result
	task ev(input logic c, input logic p, input logic o, input logic d, input logic [31:0] x);
		apb(1'b1, 12'h000, 32'h0000_0010);
		wclr <= c;
		ps <= p;
		psop <= o;
		arm <= d;
		@(posedge clk);
		wclr <= 1'b0;
		ps <= 1'b0;
		@(posedge clk);
		apb(1'b0, 12'h000, 32'h0000_0000);
		chk(rd, x);
	endtask : ev

	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			fail_count++;
			conclude();
		end
	end

	initial
	begin
		{psel, pen, pwr, cfg, wclr, ps, psop, arm, rst_b} = '0;
		addr = '0;
		wd = '0;
		src = '0;
		fz = 2'h0;
		lf = 32'h0000_66b0;
		flg = '{16'h0003, 16'h0080, 16'h0040, 16'h0010, 16'h0002, 16'h0200, 16'h8000, 16'h4000, 16'h4000};
		repeat (16) @(posedge clk);
		rst_b <= 1'b1;
		wrel();
		apb(1'b0, 12'h000, 32'h0000_0000);
		chk(rd, 32'h0000_0003);
		for (int i = 0; i < 9; i++)
		begin
			lf = nx(lf);
			apb(1'b1, 12'h000, lf);
			src[i] <= 1'b1;
			repeat (4) @(posedge clk);
			chk(mr, 32'h0000_0001);
			src[i] <= 1'b0;
			@(posedge clk);
			wrel();
			apb(1'b0, 12'h000, 32'h0000_0000);
			chk(rd, i == 0 ? 32'h0000_0003 : (lf & 32'h0000_D7FF) | flg[i]);
		end
		repeat (24)
		begin
			lf = nx(lf);
			cfg <= lf[16];
			fz <= lf[18:17];
			apb(1'b1, 12'h000, lf);
			chk(mr, 32'h0000_0000);
			repeat (2) @(posedge clk);
			chk(fb, lf[8]);
			chk(ret, lf[12] & ~lf[16]);
			chk(we, lf[5] | (lf[18:17] == 2'h3));
			apb(1'b0, 12'h000, 32'h0000_0000);
			chk(rd, lf & 32'h0000_D7FF);
			apb(1'b0, 12'h004, 32'h0000_0000);
			chk(rd, {27'h0, 2'h1, lf[18:17], lf[16]});
		end
		ev(1'b0, 1'b1, 1'b0, 1'b1, 32'h0000_0408);
		ev(1'b0, 1'b1, 1'b1, 1'b1, 32'h0000_0004);
		ev(1'b1, 1'b0, 1'b0, 1'b0, 32'h0000_0000);
		ev(1'b0, 1'b1, 1'b0, 1'b0, 32'h0000_0008);
		apb(1'b1, 12'h008, 32'h0000_FFFF);
		chk(e, 32'h0000_0001);
		apb(1'b1, 12'h004, 32'h0000_FFFF);
		chk(e, 32'h0000_0001);
		apb(1'b0, 12'h000, 32'h0000_0000);
		chk(rd, 32'h0000_0008);
		rst_b <= 1'b0;
		repeat (2) @(posedge clk);
		rst_b <= 1'b1;
		wrel();
		apb(1'b0, 12'h000, 32'h0000_0000);
		chk(rd, 32'h0000_0003);
		conclude();
	end
endmodule : test_reset_source_combiner_status
